// file: core/twa_pkg.sv
// twa_pkg: constants, states and carriers of the tape word assembler.
// assumes a 10 MHz core clock and a 32-bit apb register port.
package twa_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned PULSE_DELAY_NS = 1000;
  // longest inter-pulse time rounds down, never below one cycle
  localparam int unsigned PULSE_DELAY_CYC =
    (PULSE_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1
                                         : PULSE_DELAY_NS / CLK_PERIOD_NS;

  localparam int unsigned CHAR_W = 6;
  localparam int unsigned HALF_W = 18;
  localparam int unsigned CNT_W  = 8;
  localparam logic [CNT_W-1:0] DELAY_LOAD = CNT_W'(PULSE_DELAY_CYC - 1);
  localparam logic [1:0] LAST_STROBE = 2'h2;

  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_CMD     = 12'h004;
  localparam logic [11:0] ADDR_STATUS  = 12'h008;
  localparam logic [11:0] ADDR_DATA_UP = 12'h00c;
  localparam logic [11:0] ADDR_DATA_LO = 12'h010;

  // control register bit positions and reset value
  localparam int unsigned CTRL_READ   = 0;
  localparam int unsigned CTRL_FWD    = 1;
  localparam int unsigned CTRL_READY  = 2;
  localparam int unsigned CTRL_ERR2   = 3;
  localparam int unsigned CTRL_WSETUP = 4;
  localparam int unsigned CTRL_ACTIVE = 5;
  localparam logic [5:0] CTRL_RESET  = 6'h00;
  // command register bit positions
  localparam int unsigned CMD_CLEAR = 0;
  localparam int unsigned CMD_SET   = 1;

  typedef enum logic [2:0] {
    TWA_IDLE  = 3'b000,
    TWA_WAIT2 = 3'b001,
    TWA_WAIT3 = 3'b010,
    TWA_WAIT4 = 3'b011,
    TWA_WAIT5 = 3'b100,
    TWA_WAIT6 = 3'b101
  } twa_seq_e;

  // msb first, so every field lands on its CTRL_* bit
  typedef struct packed {
    logic active;
    logic write_setup_flag;
    logic error_count_bit2;
    logic function_ready_level;
    logic dir_forward_level;
    logic read_function_level;
  } twa_ctrl_s;

  typedef struct packed {
    logic strobe_s1;
    logic strobe_s2;
    logic strobe_s3;
    logic [CHAR_W-1:0] char_s1;
    logic [CHAR_W-1:0] char_s2;
  } twa_sync_s;

endpackage

// file: core/twa_word_assembler.sv
// twa_word_assembler: packs tape characters into 36-bit words on reads
// and unpacks words into characters on forward writes, apb registers.
// assumes tape strobe and character arrive asynchronously, held stable.
//
// Overview of operation
// - read fifth pulse moves lower half up, loads lower from shifter
// - half counter returning to zero sets the data request flag
// - unanswered read request does not stop loading new characters
// - reverse first pulse loads char bits 0-2 then 3-5 into shifter
// - reverse second pulse shifts left six with end-around
// - first two strobes of a half word suppress the third pulse
// - third strobe with error bit 2 clear and read starts third pulse
// - reverse third pulse does one final six-bit end-around shift
// - reverse fourth pulse with counter set raises the swap flag
// - swap flag makes fifth pulse relaunch fourth, clearing swap, loading
// - load-shifter copies upper half; fifth pulses then order full word
// - sixth pulse after first half loaded sets the half counter
// - write sequence starts at third pulse on ready without read
// - processor answers write request; then sequence fills the buffer
// - write gate passes top six shifter bits to tape per strobe
// - write first two strobes give only first and second pulses
// - write third strobe runs full sequence, loads second half, requests
// - last write strobe loads next word and upper half into shifter
// - write request unanswered by third pulse sets data miss and halts
// - forward first pulse shifts left six, loads char on read unless write setup
// - processor input clears request; control clear clears counter, request
// - control set raises request; processor output load clears it
`timescale 1ns/100ps
module twa_word_assembler
  import twa_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              char_strobe,
  input  wire logic [CHAR_W-1:0] read_write_char_buffer,
  output logic      [CHAR_W-1:0] write_char,
  output logic                   write_forward_gate,
  output logic                   data_request_flag,
  output logic                   data_miss_flag
);

  typedef struct packed {
    twa_sync_s             sync;
    twa_ctrl_s             ctrl;
    twa_seq_e              seq;
    logic [CNT_W-1:0]      cnt;
    logic [1:0]            strobe_cnt;
    logic                  half_word_counter;
    logic                  data_request_flag;
    logic                  reverse_swap_flag;
    logic                  data_miss_flag;
    logic                  write_started;
    logic [HALF_W-1:0]     assembly_shift_reg;
    logic [HALF_W-1:0]     buffer_upper_half;
    logic [HALF_W-1:0]     buffer_lower_half;
    logic [HALF_W-1:0]     out_stage_upper;
    logic [2*HALF_W-1:0]   out_word;
  } twa_state_s;

  twa_state_s s;
  twa_state_s next_s;

  logic             acc;
  logic             wr_acc;
  logic             rd_acc;
  logic             mapped;
  logic             strobe_edge;
  logic             reading;
  logic             reverse;
  logic             write_fwd;
  logic             processor_input_instr;
  logic             processor_output_instr;
  logic             control_clear_pulse;
  logic             control_set_pulse;
  logic [HALF_W-1:0] sh_rot;

  assign acc     = psel && penable;
  assign wr_acc  = acc && pwrite;
  assign rd_acc  = acc && !pwrite;
  assign mapped  = (paddr == ADDR_CTRL) || (paddr == ADDR_CMD) ||
                   (paddr == ADDR_STATUS) || (paddr == ADDR_DATA_UP) ||
                   (paddr == ADDR_DATA_LO);
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  assign processor_input_instr  = rd_acc && (paddr == ADDR_DATA_LO);
  assign processor_output_instr = wr_acc && (paddr == ADDR_DATA_LO);
  assign control_clear_pulse    = wr_acc && (paddr == ADDR_CMD) &&
                                  pwdata[CMD_CLEAR];
  assign control_set_pulse      = wr_acc && (paddr == ADDR_CMD) &&
                                  pwdata[CMD_SET];

  assign strobe_edge = s.sync.strobe_s2 && !s.sync.strobe_s3;
  assign reading     = s.ctrl.read_function_level;
  assign reverse     = !s.ctrl.dir_forward_level;
  assign write_fwd   = !reading && s.ctrl.dir_forward_level;
  // six-bit left shift with the top character wrapped to the bottom
  assign sh_rot = {s.assembly_shift_reg[HALF_W-CHAR_W-1:0],
                   s.assembly_shift_reg[HALF_W-1:HALF_W-CHAR_W]};

  assign write_char = s.assembly_shift_reg[HALF_W-1:HALF_W-CHAR_W];
  assign write_forward_gate = s.ctrl.active && write_fwd &&
                              s.write_started && !s.data_miss_flag;
  assign data_request_flag = s.data_request_flag;
  assign data_miss_flag    = s.data_miss_flag;

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      unique case (paddr)
        ADDR_CTRL:    prdata = {26'h000_0000, s.ctrl};
        ADDR_STATUS:  prdata = {22'h00_0000, s.seq, s.strobe_cnt,
                                s.write_started, s.reverse_swap_flag,
                                s.data_miss_flag, s.half_word_counter,
                                s.data_request_flag};
        ADDR_DATA_UP: prdata = {14'h0000, s.buffer_upper_half};
        ADDR_DATA_LO: prdata = {14'h0000, s.buffer_lower_half};
        default:      prdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_s = s;
    // two-flop synchronisers on the tape side inputs
    next_s.sync.strobe_s1 = char_strobe;
    next_s.sync.strobe_s2 = s.sync.strobe_s1;
    next_s.sync.strobe_s3 = s.sync.strobe_s2;
    next_s.sync.char_s1   = read_write_char_buffer;
    next_s.sync.char_s2   = s.sync.char_s1;

    if (wr_acc && paddr == ADDR_CTRL) begin
      next_s.ctrl = pwdata[5:0];
    end
    if (wr_acc && paddr == ADDR_DATA_UP) begin
      next_s.out_stage_upper = pwdata[HALF_W-1:0];
    end

    // clears first, so that a hardware set in the same cycle wins
    if (processor_input_instr) begin
      next_s.data_request_flag = 1'b0;
    end
    if (processor_output_instr) begin
      next_s.out_word          = {s.out_stage_upper, pwdata[HALF_W-1:0]};
      next_s.data_request_flag = 1'b0;
    end
    if (control_set_pulse) begin
      next_s.data_request_flag = 1'b1;
      next_s.write_started     = 1'b0;
      next_s.half_word_counter = 1'b0;
      next_s.strobe_cnt        = 2'h0;
    end

    if (s.cnt != '0) begin
      next_s.cnt = s.cnt - CNT_W'(1);
    end

    unique case (s.seq)
      TWA_IDLE: begin
        if (s.ctrl.active && !s.data_miss_flag && strobe_edge &&
            (reading || s.write_started)) begin
          // first pulse
          next_s.assembly_shift_reg = sh_rot;
          if (reading && !s.ctrl.write_setup_flag) begin
            if (s.ctrl.dir_forward_level) begin
              next_s.assembly_shift_reg[CHAR_W-1:0] = s.sync.char_s2;
            end else begin
              next_s.assembly_shift_reg[5:3] = s.sync.char_s2[2:0];
              next_s.assembly_shift_reg[2:0] = s.sync.char_s2[5:3];
            end
          end
          next_s.seq = TWA_WAIT2;
          next_s.cnt = DELAY_LOAD;
        end else if (s.ctrl.active && !s.data_miss_flag && write_fwd &&
                     s.ctrl.function_ready_level && !s.write_started &&
                     !s.data_request_flag && !control_set_pulse) begin
          next_s.write_started = 1'b1;
          next_s.seq           = TWA_WAIT3;
          next_s.cnt           = '0;
        end
      end
      TWA_WAIT2: begin
        if (s.cnt == '0) begin
          if (reading && reverse) begin
            next_s.assembly_shift_reg = sh_rot;
          end
          if (s.strobe_cnt == LAST_STROBE) begin
            next_s.strobe_cnt = 2'h0;
          end else begin
            next_s.strobe_cnt = s.strobe_cnt + 2'h1;
          end
          if (s.strobe_cnt == LAST_STROBE &&
              ((reading && !s.ctrl.error_count_bit2) || !reading)) begin
            next_s.seq = TWA_WAIT3;
            next_s.cnt = DELAY_LOAD;
          end else begin
            next_s.seq = TWA_IDLE;
          end
        end
      end
      TWA_WAIT3: begin
        if (s.cnt == '0) begin
          next_s.seq = TWA_WAIT4;
          next_s.cnt = DELAY_LOAD;
          if (reading && reverse) begin
            next_s.assembly_shift_reg = sh_rot;
          end
          if (!reading && !s.half_word_counter &&
              s.data_request_flag) begin
            next_s.data_miss_flag = 1'b1;
            next_s.seq            = TWA_IDLE;
          end
        end
      end
      TWA_WAIT4: begin
        if (s.cnt == '0) begin
          next_s.seq = TWA_WAIT5;
          next_s.cnt = DELAY_LOAD;
          if (s.reverse_swap_flag) begin
            next_s.reverse_swap_flag  = 1'b0;
            next_s.assembly_shift_reg = s.buffer_upper_half;
          end else if (reading && reverse && s.half_word_counter) begin
            next_s.reverse_swap_flag = 1'b1;
          end
        end
      end
      TWA_WAIT5: begin
        if (s.cnt == '0) begin
          next_s.cnt = DELAY_LOAD;
          if (reading) begin
            next_s.buffer_upper_half = s.buffer_lower_half;
            next_s.buffer_lower_half = s.assembly_shift_reg;
          end else if (!s.half_word_counter) begin
            next_s.buffer_upper_half  = s.out_word[2*HALF_W-1:HALF_W];
            next_s.buffer_lower_half  = s.out_word[HALF_W-1:0];
            next_s.assembly_shift_reg = s.out_word[2*HALF_W-1:HALF_W];
          end else begin
            next_s.assembly_shift_reg = s.buffer_lower_half;
          end
          // swap relaunches the fourth pulse instead of the sixth
          next_s.seq = s.reverse_swap_flag ? TWA_WAIT4 : TWA_WAIT6;
        end
      end
      TWA_WAIT6: begin
        if (s.cnt == '0) begin
          next_s.seq = TWA_IDLE;
          if (!s.half_word_counter) begin
            next_s.half_word_counter = 1'b1;
          end else begin
            next_s.half_word_counter = 1'b0;
            next_s.data_request_flag = 1'b1;
          end
        end
      end
      default: begin
        next_s.seq = TWA_IDLE;
      end
    endcase

    // control clear aborts the chain and wins over everything else
    if (control_clear_pulse) begin
      next_s.half_word_counter = 1'b0;
      next_s.data_request_flag = 1'b0;
      next_s.data_miss_flag    = 1'b0;
      next_s.reverse_swap_flag = 1'b0;
      next_s.write_started     = 1'b0;
      next_s.strobe_cnt        = 2'h0;
      next_s.seq               = TWA_IDLE;
      next_s.cnt               = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s      <= '0;
      s.ctrl <= CTRL_RESET;
      s.seq  <= TWA_IDLE;
    end else begin
      s <= next_s;
    end
  end

endmodule

// file: verif/twa_word_assembler_monitor.sv
// twa_word_assembler_mon: port-level checks of the word assembler.
// assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/100ps
module twa_word_assembler_mon
  import twa_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              char_strobe,
  input wire logic [CHAR_W-1:0] write_char,
  input wire logic              write_forward_gate,
  input wire logic              data_request_flag,
  input wire logic              data_miss_flag
);
  localparam int QUIET = 110;
  logic       acc, wr_any, clr_wr, set_wr, rd_lo, wr_lo, calm, strobe_q;
  logic [7:0] quiet;
  assign acc    = psel && penable;
  assign wr_any = acc && pwrite;
  assign clr_wr = wr_any && paddr == ADDR_CMD && pwdata[CMD_CLEAR];
  assign set_wr = wr_any && paddr == ADDR_CMD && pwdata[CMD_SET];
  assign rd_lo  = acc && !pwrite && paddr == ADDR_DATA_LO;
  assign wr_lo  = wr_any && paddr == ADDR_DATA_LO;
  assign calm   = quiet >= 8'(QUIET);
  // no chain is still running once nothing could have started one
  always_ff @(posedge clk) begin
    strobe_q <= char_strobe;
    if (rst || (char_strobe && !strobe_q) ||
        (wr_any && paddr == ADDR_CTRL && pwdata[CTRL_READY]))
      quiet <= 8'h00;
    else if (quiet != 8'hff)
      quiet <= quiet + 8'h01;
  end
  sequence s_req_up;
    !data_request_flag ##1 data_request_flag;
  endsequence
  sequence s_miss_up;
    !data_miss_flag ##1 data_miss_flag;
  endsequence
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_miss_shuts_gate:
    assert property (data_miss_flag |-> !write_forward_gate)
    else $error("write gate open while miss set");
  chk_miss_holds:
    assert property (data_miss_flag && !clr_wr |=> data_miss_flag)
    else $error("miss dropped without control clear");
  chk_miss_cause:
    assert property (s_miss_up |->
      $past(data_request_flag) && $past(write_forward_gate))
    else $error("miss set without open write request");
  chk_clear_all:
    assert property (clr_wr |-> ##1 !data_request_flag && !data_miss_flag)
    else $error("control clear left a flag set");
  chk_set_request:
    assert property (set_wr && !clr_wr |=> data_request_flag)
    else $error("control set did not raise request");
  chk_input_clears:
    assert property (rd_lo && calm |=> !data_request_flag)
    else $error("input transfer left request set");
  chk_output_clears:
    assert property (wr_lo && calm |=> !data_request_flag)
    else $error("output transfer left request set");
  chk_req_cause:
    assert property (s_req_up |-> $past(set_wr) || quiet < 8'(QUIET))
    else $error("request raised with no cause");
  chk_char_still:
    assert property (calm && !wr_any |=> $stable(write_char))
    else $error("write char moved with no chain");
endmodule
bind twa_word_assembler twa_word_assembler_mon mon_u (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .char_strobe(char_strobe),
  .write_char(write_char), .write_forward_gate(write_forward_gate),
  .data_request_flag(data_request_flag), .data_miss_flag(data_miss_flag));

// file: verif/twa_tape_model.sv
// twa_tape_model: tape side, one character per strobe.
// assumes the caller enters send just after a rising clock edge.
`timescale 1ns/100ps
module twa_tape_model
  import twa_pkg::*;
(
  input  wire logic              clk,
  output logic                   char_strobe,
  output logic      [CHAR_W-1:0] read_write_char_buffer
);
  initial begin
    char_strobe = 1'b0;
    read_write_char_buffer = 6'h2a;
  end
  task automatic send(input logic [CHAR_W-1:0] c, input int lead);
    read_write_char_buffer <= c;
    repeat (lead) @(posedge clk);
    char_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    char_strobe <= 1'b0;
    // next strobe only after the longest chain
    repeat (110) @(posedge clk);
    read_write_char_buffer <= ~c;
    // one edge, so a following send never writes the char twice a step
    @(posedge clk);
  endtask
endmodule

// file: verif/testbench.sv
// testbench: apb master plus tape model around the word assembler.
// assumes twa_pkg, the design and the tape model are compiled first.
`timescale 1ns/100ps
module testbench
  import twa_pkg::*;
;
  logic              clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, lfsr;
  logic              char_strobe, write_forward_gate;
  logic              data_request_flag, data_miss_flag;
  logic [CHAR_W-1:0] read_write_char_buffer, write_char;
  logic [32:0]       exp_q[$];
  int                n_errors, checks_done, cycles;
  twa_word_assembler dut_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .char_strobe(char_strobe),
    .read_write_char_buffer(read_write_char_buffer),
    .write_char(write_char), .write_forward_gate(write_forward_gate),
    .data_request_flag(data_request_flag), .data_miss_flag(data_miss_flag));
  twa_tape_model tape_u (
    .clk(clk), .char_strobe(char_strobe),
    .read_write_char_buffer(read_write_char_buffer));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic err);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic run_read(input logic rev);
    logic [35:0] acc;
    logic [5:0]  c;
    apb(1'b1, ADDR_CMD, 32'h0000_0001);
    apb(1'b1, ADDR_CTRL, rev ? 32'h0000_0021 : 32'h0000_0023);
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      c = lfsr[5:0];
      tape_u.send(c, 3 + int'(lfsr[9:8]));
      // reverse: halves of each char swapped, low-order char first
      acc = rev ? {c[2:0], c[5:3], acc[35:6]} : {acc[29:0], c};
      if (i == 2) begin
        check(data_request_flag, 1'b0);
        rd(ADDR_STATUS, 32'h0000_0002, 1'b0);
        rd(ADDR_DATA_LO, {14'h0000, rev ? acc[35:18] : acc[17:0]},
           1'b0);
      end
    end
    check(data_request_flag, 1'b1);
    rd(ADDR_DATA_UP, {14'h0000, acc[35:18]}, 1'b0);
    rd(ADDR_DATA_LO, {14'h0000, acc[17:0]}, 1'b0);
    check(data_request_flag, 1'b0);
  endtask
  // read answers land here in issue order
  always @(posedge clk) begin
    cycles++;
    if (cycles == 9000) begin
      n_errors++;
      conclude();
    end else if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("[FAIL] %0t read with no expectation", $time);
      end else begin
        check({pslverr, prdata}, exp_q.pop_front());
      end
    end
  end
  initial begin
    logic [71:0] w;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    lfsr = 32'h0000_7095;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_CTRL, 32'h0000_0000, 1'b0);
    rd(12'h014, 32'h0000_0000, 1'b1);
    run_read(1'b0);
    run_read(1'b1);
    // error bit 2 set: third pulse never comes, half counter stays clear
    apb(1'b1, ADDR_CMD, 32'h0000_0001);
    apb(1'b1, ADDR_CTRL, 32'h0000_002b);
    for (int i = 0; i < 3; i++) tape_u.send(6'h15, 3);
    rd(ADDR_STATUS, 32'h0000_0000, 1'b0);
    apb(1'b1, ADDR_CMD, 32'h0000_0001);
    apb(1'b1, ADDR_CTRL, 32'h0000_0032);
    apb(1'b1, ADDR_CMD, 32'h0000_0002);
    check(data_request_flag, 1'b1);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      w[71-18*i -: 18] = lfsr[17:0];
    end
    apb(1'b1, ADDR_DATA_UP, {14'h0000, w[71:54]});
    apb(1'b1, ADDR_DATA_LO, {14'h0000, w[53:36]});
    check(data_request_flag, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0036);
    repeat (50) @(posedge clk);
    check(write_forward_gate, 1'b1);
    // third word's request left unanswered on purpose to provoke a miss
    for (int i = 0; i < 12; i++) begin
      check(write_char, w[71-6*i -: 6]);
      tape_u.send(6'h00, 3);
      if (i == 2 || i == 8) check(data_request_flag, 1'b1);
      if (i == 2) begin
        apb(1'b1, ADDR_DATA_UP, {14'h0000, w[35:18]});
        apb(1'b1, ADDR_DATA_LO, {14'h0000, w[17:0]});
        check(data_request_flag, 1'b0);
      end
    end
    check(data_miss_flag, 1'b1);
    check(write_forward_gate, 1'b0);
    apb(1'b1, ADDR_CMD, 32'h0000_0001);
    check({data_miss_flag, data_request_flag}, 2'b00);
    conclude();
  end
endmodule
